// ### src/sepc_top.sv
// two-wire eeprom target: pin sampling, select, inhibit, write cycle, apb
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - The storage array holds 128 K bytes of eight bits each.
// - An extra 256-byte identification page exists and can be locked.
// - The serial clock samples incoming data and times outgoing data.
// - The data line is only ever pulled low or released.
// - Select bits b3 and b2 must equal the two strap inputs to respond.
// - Unconnected strap inputs count as zero.
// - A high write-inhibit input blocks every write to the memory.
// - A low or floating write-inhibit input allows writes.
// - With inhibit high, select and address bytes are acked, data not.
// - Bus traffic is ignored until the power-on reset is released.
// - Reset release initialises logic and enters standby.
// - Reset asserting again stops all bus responses.
// - A stop condition enters standby unless a write cycle runs.
// - Select byte is msb first: type, straps, top address bit, rw.
// - A matching select is acked on the ninth clock, else standby.
// - A stop right after a data ack starts the write cycle, mute.
module sepc_top
    import sepc_pkg::*;
#(
    parameter int TW_CYCLES_P = TW_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic strap_select_low,
    input wire logic strap_select_high,
    input wire logic write_inhibit_pin
);
    localparam logic [19:0] TW_LAST = 20'(TW_CYCLES_P - 1);

    logic [SY_N-1:0] pins_in;
    logic [SY_N-1:0] pins_s;
    logic scl_q_reg, sda_q_reg;
    sepc_state_t state_reg;
    sepc_phase_t phase_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg, tx_reg;
    logic [16:0] addr_reg;
    logic rw_reg, idsel_reg, wr_pend_reg, sda_oe_reg, sda_o_reg;
    logic [PAGE_DEPTH-1:0] valid_reg;
    logic [19:0] cyc_reg;
    logic copy_act_reg;
    logic [7:0] copy_idx_reg;
    logic [1:0] ctrl_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic [7:0] arr_rdata, buf_rdata;

    // every pin passes two flops; pads pull straps and inhibit low
    assign pins_in = {write_inhibit_pin, strap_select_high,
                      strap_select_low, sda_i, scl_i};
    for (genvar i = 0; i < SY_N; i++) begin : g_sync
        // clock and data idle high: leaving reset high avoids false edges
        localparam logic RST_LVL = (i == SY_SCL) || (i == SY_SDA);
        logic m1_reg, s_reg;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                m1_reg <= RST_LVL;
                s_reg <= RST_LVL;
            end else begin
                m1_reg <= pins_in[i];
                s_reg <= m1_reg;
            end
        end
        assign pins_s[i] = s_reg;
    end

    // edge history for start, stop and clock edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= pins_s[SY_SCL];
            sda_q_reg <= pins_s[SY_SDA];
        end
    end

    // bus event decode
    wire scl = pins_s[SY_SCL];
    wire sda = pins_s[SY_SDA];
    wire scl_rise = scl & ~scl_q_reg;
    wire scl_fall = ~scl & scl_q_reg;
    wire start_det = scl & scl_q_reg & sda_q_reg & ~sda;
    wire stop_det = scl & scl_q_reg & ~sda_q_reg & sda;
    wire busy = (state_reg == ST_WCYCLE);
    wire byte_end = (state_reg == ST_RECV) && scl_fall &&
                    (bit_reg == BYTE_BITS);

    // select decode; a floating strap arrives here as zero
    wire [3:0] sel_type = shift_reg[7:4];
    wire ce_ok = (shift_reg[SEL_CE_HI] == pins_s[SY_CE_HI]) &&
                 (shift_reg[SEL_CE_LO] == pins_s[SY_CE_LO]);
    wire type_ok = (sel_type == TYPE_ARRAY) ||
                   ((sel_type == TYPE_IDPAGE) && ctrl_reg[CTRL_IDEN]);
    wire sel_match = ce_ok && type_ok;
    // inhibit low or floating (pulled low) lets data in
    wire wr_allowed = ~pins_s[SY_WI] &
                      ~(idsel_reg & ctrl_reg[CTRL_IDLOCK]);
    wire ack_now = (phase_reg == PH_SEL) ? sel_match :
                   (phase_reg == PH_DATA) ? wr_allowed : 1'b1;
    // a stop only counts in the slot right after a data ack; the stop's
    // own clock rise has already been counted as one bit by then
    wire wr_trig = wr_pend_reg && (state_reg == ST_RECV) &&
                   (phase_reg == PH_DATA) && (bit_reg == 4'h1);
    wire buf_we = byte_end && (phase_reg == PH_DATA) && wr_allowed;
    wire arr_we = copy_act_reg && valid_reg[copy_idx_reg];

    // storage addressing; the id page sits just above the array
    wire [MEM_AW-1:0] arr_raddr = idsel_reg ?
        {1'b1, 9'h000, addr_reg[7:0]} : {1'b0, addr_reg};
    wire [MEM_AW-1:0] arr_waddr = idsel_reg ?
        {1'b1, 9'h000, copy_idx_reg} : {1'b0, addr_reg[16:8], copy_idx_reg};

    sepc_mem #(.AW(MEM_AW), .DEPTH(MEM_DEPTH), .DW(8)) u_array (
        .clk(pclk),
        .we(arr_we),
        .waddr(arr_waddr),
        .wdata(buf_rdata),
        .raddr(arr_raddr),
        .rdata(arr_rdata)
    );

    // page latch: bytes wait here until the stop starts the write cycle
    sepc_mem #(.AW(PAGE_AW), .DEPTH(PAGE_DEPTH), .DW(8)) u_page (
        .clk(pclk),
        .we(buf_we),
        .waddr(addr_reg[7:0]),
        .wdata(shift_reg),
        .raddr(cyc_reg[7:0]),
        .rdata(buf_rdata)
    );

    // copy pipeline: page read one cycle, array write the next
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            copy_act_reg <= 1'b0;
            copy_idx_reg <= 8'h00;
        end else begin
            copy_act_reg <= busy && (cyc_reg < COPY_END);
            copy_idx_reg <= cyc_reg[7:0];
        end
    end

    // protocol and write-cycle sequencer; reset is the supply detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_STANDBY;
            phase_reg <= PH_SEL;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            addr_reg <= 17'h00000;
            rw_reg <= 1'b0;
            idsel_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            valid_reg <= '0;
            cyc_reg <= 20'h00000;
            sda_oe_reg <= 1'b0;
            sda_o_reg <= 1'b0;
        end else if (!busy && start_det) begin
            state_reg <= ST_RECV;
            phase_reg <= PH_SEL;
            bit_reg <= 4'h0;
            wr_pend_reg <= 1'b0;
            valid_reg <= '0;
            sda_oe_reg <= 1'b0;
        end else if (!busy && stop_det) begin
            sda_oe_reg <= 1'b0;
            cyc_reg <= 20'h00000;
            state_reg <= wr_trig ? ST_WCYCLE : ST_STANDBY;
            if (!wr_trig) begin
                wr_pend_reg <= 1'b0;
                valid_reg <= '0;
            end
        end else begin
            case (state_reg)
                ST_RECV: begin
                    if (scl_rise && bit_reg != BYTE_BITS) begin
                        shift_reg <= {shift_reg[6:0], sda};
                        bit_reg <= bit_reg + 4'h1;
                    end
                    if (byte_end) begin
                        bit_reg <= 4'h0;
                        sda_oe_reg <= ack_now;
                        state_reg <= ST_ACK;
                        case (phase_reg)
                            PH_SEL: begin
                                rw_reg <= shift_reg[SEL_RW_BIT];
                                idsel_reg <= (sel_type == TYPE_IDPAGE);
                                addr_reg[16] <= shift_reg[SEL_TOP_BIT];
                                if (!sel_match) begin
                                    state_reg <= ST_STANDBY;
                                end
                            end
                            PH_AHI: addr_reg[15:8] <= shift_reg;
                            PH_ALO: addr_reg[7:0] <= shift_reg;
                            default: begin
                                if (wr_allowed) begin
                                    valid_reg[addr_reg[7:0]] <= 1'b1;
                                    wr_pend_reg <= 1'b1;
                                    // page roll-over: only the low byte moves
                                    addr_reg[7:0] <= addr_reg[7:0] + 8'h01;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (phase_reg == PH_SEL && rw_reg) begin
                            // first data bit goes out on the ack's fall
                            state_reg <= ST_SEND;
                            tx_reg <= arr_rdata;
                            sda_oe_reg <= ~arr_rdata[7];
                            bit_reg <= 4'h1;
                            addr_reg <= addr_reg + 17'h00001;
                        end else begin
                            state_reg <= ST_RECV;
                            sda_oe_reg <= 1'b0;
                            if (phase_reg != PH_DATA) begin
                                phase_reg <= sepc_phase_t'(phase_reg + 2'h1);
                            end
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (bit_reg == BYTE_BITS) begin
                            sda_oe_reg <= 1'b0;
                            bit_reg <= 4'h0;
                            state_reg <= ST_HOSTACK;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe_reg <= ~tx_reg[6];
                            bit_reg <= bit_reg + 4'h1;
                        end
                    end
                end
                ST_HOSTACK: begin
                    // controller ack asks for the next byte, noack ends it
                    if (scl_rise) begin
                        state_reg <= sda ? ST_WAITSTOP : ST_ACK;
                    end
                end
                ST_WCYCLE: begin
                    sda_oe_reg <= 1'b0;
                    cyc_reg <= cyc_reg + 20'h00001;
                    if (cyc_reg == TW_LAST) begin
                        state_reg <= ST_STANDBY;
                        wr_pend_reg <= 1'b0;
                        valid_reg <= '0;
                    end
                end
                default: sda_oe_reg <= 1'b0;
            endcase
        end
    end

    assign sda_o = sda_o_reg;
    assign sda_oe = sda_oe_reg;

    // apb decode; no wait state, pready and the answer are registered in the setup cycle
    wire setup = psel & ~penable;
    wire hit_ctrl = (paddr == CTRL_OFF);
    wire hit_stat = (paddr == STAT_OFF);
    wire apb_wr = psel & penable & pready_reg & pwrite & hit_ctrl;
    wire [31:0] stat_val = {27'h0000000, pins_s[SY_CE_HI],
                            pins_s[SY_CE_LO], pins_s[SY_WI],
                            (state_reg != ST_STANDBY), busy};
    wire [31:0] rd_val = hit_ctrl ? {30'h00000000, ctrl_reg} :
                         hit_stat ? stat_val : 32'h00000000;

    // apb slave registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~hit_ctrl & ~hit_stat;
            prdata_reg <= setup ? rd_val : 32'h00000000;
            if (apb_wr) begin
                ctrl_reg <= pwdata[1:0];
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // checks kept next to the logic they guard
    property p_open_drain;
        @(posedge pclk) disable iff (!presetn)
        sda_oe_reg |-> !sda_o_reg;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data line driven high");

    property p_mute_cycle;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_WCYCLE) |=> !sda_oe_reg;
    endproperty
    a_mute_cycle: assert property (p_mute_cycle)
        else $error("data line driven during write cycle");

    property p_cycle_start;
        @(posedge pclk) disable iff (!presetn)
        (!busy && stop_det && wr_trig) |=> (state_reg == ST_WCYCLE);
    endproperty
    a_cycle_start: assert property (p_cycle_start)
        else $error("stop after data ack did not start write cycle");

    property p_sel_miss;
        @(posedge pclk) disable iff (!presetn)
        (byte_end && phase_reg == PH_SEL && !sel_match && !start_det &&
         !stop_det) |=> (state_reg == ST_STANDBY) && !sda_oe_reg;
    endproperty
    a_sel_miss: assert property (p_sel_miss)
        else $error("mismatching select not dropped");

    property p_sel_ack;
        @(posedge pclk) disable iff (!presetn)
        (byte_end && phase_reg == PH_SEL && !start_det && !stop_det)
        |=> (sda_oe_reg == $past(ce_ok && type_ok));
    endproperty
    a_sel_ack: assert property (p_sel_ack)
        else $error("select ack does not follow strap match");

    property p_inhibit_nack;
        @(posedge pclk) disable iff (!presetn)
        (byte_end && phase_reg == PH_DATA && pins_s[SY_WI] && !start_det &&
         !stop_det) |=> !sda_oe_reg ##1 !sda_oe_reg;
    endproperty
    a_inhibit_nack: assert property (p_inhibit_nack)
        else $error("data byte acked while inhibited");

    property p_addr_ack;
        @(posedge pclk) disable iff (!presetn)
        (byte_end && (phase_reg == PH_AHI || phase_reg == PH_ALO) &&
         !start_det && !stop_det) |=> sda_oe_reg && state_reg == ST_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address byte not acked");

    property p_stop_standby;
        @(posedge pclk) disable iff (!presetn)
        (!busy && stop_det && !wr_trig) |=> (state_reg == ST_STANDBY);
    endproperty
    a_stop_standby: assert property (p_stop_standby)
        else $error("stop did not enter standby");

    property p_write_only_cycle;
        @(posedge pclk) disable iff (!presetn)
        arr_we |-> $past(busy);
    endproperty
    a_write_only_cycle: assert property (p_write_only_cycle)
        else $error("array written outside write cycle");

    property p_inhibit_keep;
        @(posedge pclk) disable iff (!presetn)
        (byte_end && phase_reg == PH_DATA && pins_s[SY_WI])
        |=> $stable(valid_reg);
    endproperty
    a_inhibit_keep: assert property (p_inhibit_keep)
        else $error("inhibited data byte marked for writing");

    property p_drive_on_fall;
        @(posedge pclk) disable iff (!presetn)
        $rose(sda_oe_reg) |-> $past(scl_fall);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall)
        else $error("data line pulled low away from a clock fall");
endmodule
`default_nettype wire

// ### include/sepc_pkg.sv
// constants and types shared by the serial eeprom pin control block
package sepc_pkg;
    // storage geometry
    localparam int ARR_DEPTH = 131072;
    localparam int ID_DEPTH = 256;
    localparam int MEM_DEPTH = ARR_DEPTH + ID_DEPTH;
    localparam int MEM_AW = 18;
    localparam int PAGE_AW = 8;
    localparam int PAGE_DEPTH = 256;
    // select byte layout, msb first on the wire
    localparam logic [3:0] TYPE_ARRAY = 4'hA;
    localparam logic [3:0] TYPE_IDPAGE = 4'hB;
    localparam int SEL_RW_BIT = 0;
    localparam int SEL_TOP_BIT = 1;
    localparam int SEL_CE_LO = 2;
    localparam int SEL_CE_HI = 3;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // internal write cycle time
    localparam int TW_US = 5000;
    localparam int CLK_MHZ = 100;
    localparam int TW_CYCLES = TW_US * CLK_MHZ;
    localparam logic [19:0] COPY_END = 20'h00100;
    // apb register map
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int CTRL_IDEN = 0;
    localparam int CTRL_IDLOCK = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SEL = 1;
    localparam int STAT_WI = 2;
    localparam int STAT_CE_LO = 3;
    localparam int STAT_CE_HI = 4;
    // pin synchroniser slots
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_CE_LO = 2;
    localparam int SY_CE_HI = 3;
    localparam int SY_WI = 4;
    localparam int SY_N = 5;

    typedef enum logic [2:0] {
        ST_STANDBY, ST_RECV, ST_ACK, ST_SEND, ST_HOSTACK, ST_WAITSTOP,
        ST_WCYCLE
    } sepc_state_t;

    typedef enum logic [1:0] {PH_SEL, PH_AHI, PH_ALO, PH_DATA} sepc_phase_t;
endpackage

// ### src/sepc_mem.sv
// simple one-write one-read storage with registered read data
`timescale 1ns/1ns
`default_nettype none
module sepc_mem #(
    parameter int AW = 8,
    parameter int DEPTH = 256,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] store [DEPTH];

    // no reset: contents survive the power-on reset like real cells
    always_ff @(posedge clk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        rdata <= store[raddr];
    end
endmodule
`default_nettype wire

// ### bench/sepc_ctl_model.sv
// two-wire bus controller model that makes the serial clock
`timescale 1ns/1ns
`default_nettype none
module sepc_ctl_model (
    output logic scl,
    output logic pull_low,
    input wire logic sda
);
    // clock parks high between frames, data released to the pull-up
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // start or repeated start; 3 ns skew keeps edges off the pclk edge
    task automatic start();
        #3;
        #20 pull_low = 1'b0;
        #20 scl = 1'b1;
        #20 pull_low = 1'b1;
        #20 scl = 1'b0;
    endtask
    // stop leaves the clock high and the line released
    task automatic stop();
        #20 pull_low = 1'b1;
        #20 scl = 1'b1;
        #20 pull_low = 1'b0;
        #20;
    endtask
    // one 80 ns clock, data changed only while low, sampled mid-high
    task automatic pulse(input logic drv, output logic smp);
        #20 pull_low = drv;
        #20 scl = 1'b1;
        #20 smp = sda;
        #20 scl = 1'b0;
    endtask
    // byte out msb first, then the ninth clock returns the ack
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(~d[i], s);
        end
        pulse(1'b0, s);
        ack = ~s;
    endtask
    // byte in msb first, closed by a no-ack
    task automatic rd_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b0, s);
            d[i] = s;
        end
        pulse(1'b0, s);
    endtask
endmodule
`default_nettype wire

// ### bench/serial_eeprom_pin_control_test.sv
// self-checking bench for the serial eeprom pin control block
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_pin_control_test
    import sepc_pkg::*;
;
    localparam int TW = 300;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic scl, pull_low, sda_o, sda_oe, sda, ce_lo, ce_hi, wi;
    logic ack, err, od_bad, rst_bad;
    logic [7:0] b;
    int err_count, n_compared;

    // wired data line with pull-up: any pulling party wins
    assign sda = ~((sda_oe & ~sda_o) | pull_low);

    sepc_top #(.TW_CYCLES_P(TW)) uut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .strap_select_low(ce_lo),
        .strap_select_high(ce_hi), .write_inhibit_pin(wi));
    sepc_ctl_model ctl (.scl(scl), .pull_low(pull_low), .sda(sda));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // pin watch: never drive high, never pull while in reset
    always @(posedge pclk) begin
        if (presetn === 1'b1 && sda_o !== 1'b0) od_bad <= 1'b1;
        if (presetn === 1'b0 && sda_oe !== 1'b0) rst_bad <= 1'b1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // apb transfer: setup, access held until pready, then release
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tx(input logic [7:0] d, input logic exp);
        ctl.wr_byte(d, ack);
        chk({31'h0, ack}, {31'h0, exp});
    endtask
    // byte write; only the data ack depends on the case
    task automatic wr(input logic [7:0] s, input logic [15:0] a,
                      input logic [7:0] d, input logic dack);
        @(posedge pclk);
        ctl.start();
        tx(s, 1'b1);
        tx(a[15:8], 1'b1);
        tx(a[7:0], 1'b1);
        tx(d, dack);
        ctl.stop();
    endtask
    // random read: dummy write sets the address, restart reads it
    task automatic rdb(input logic [7:0] s, input logic [15:0] a,
                       input logic [7:0] exp);
        @(posedge pclk);
        ctl.start();
        tx(s, 1'b1);
        tx(a[15:8], 1'b1);
        tx(a[7:0], 1'b1);
        ctl.start();
        tx(s | 8'h01, 1'b1);
        ctl.rd_byte(b);
        ctl.stop();
        chk({24'h0, b}, {24'h0, exp});
    endtask

    // watchdog well beyond the expected 60 us of traffic
    initial begin
        #300000;
        err_count++;
        end_of_test();
    end

    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, ce_lo, ce_hi, wi} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {od_bad, rst_bad} = 2'h0;
        err_count = 0;
        n_compared = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test registers done");
        // every strap setting against every select chip-enable value
        for (int s = 0; s < 4; s++) begin
            ce_lo <= s[0];
            ce_hi <= s[1];
            for (int c = 0; c < 4; c++) begin
                repeat (4) @(posedge pclk);
                ctl.start();
                tx({4'hA, c[1:0], 2'h0}, c == s);
                ctl.stop();
            end
        end
        ce_lo <= 1'b0;
        ce_hi <= 1'b0;
        $display("test select done");
        // write at the top half, polls ignored during the write cycle
        wr(8'hA2, 16'h2345, 8'h5A, 1'b1);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd & 32'h1, 32'h1);
        @(posedge pclk);
        ctl.start();
        tx(8'hA0, 1'b0);
        ctl.stop();
        repeat (TW + 20) @(posedge pclk);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd, 32'h0);
        rdb(8'hA2, 16'h2345, 8'h5A);
        $display("test write done");
        // inhibit high: data refused, contents and busy untouched
        wi <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(8'hA2, 16'h2345, 8'hA5, 1'b0);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd, 32'h4);
        rdb(8'hA2, 16'h2345, 8'h5A);
        wi <= 1'b0;
        $display("test inhibit done");
        // identification page written, then locked
        wr(8'hB0, 16'h0010, 8'h3C, 1'b1);
        repeat (TW + 20) @(posedge pclk);
        rdb(8'hB0, 16'h0010, 8'h3C);
        apb(1'b1, CTRL_OFF, 32'h3);
        wr(8'hB0, 16'h0010, 8'hC3, 1'b0);
        rdb(8'hB0, 16'h0010, 8'h3C);
        $display("test id page done");
        // reset lands mid-frame; traffic during reset is ignored
        @(posedge pclk);
        ctl.start();
        tx(8'hA0, 1'b1);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd & 32'h2, 32'h2);
        presetn <= 1'b0;
        #3;
        ctl.start();
        tx(8'hA0, 1'b0);
        ctl.stop();
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, rst_bad}, 32'h0);
        chk({31'h0, od_bad}, 32'h0);
        $display("test reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
